// ==== verilog/bil_pkg.sv ====
// constants and carrier types for the boot image loader
// What this block does
// - while reset input is low, stay in reset and pull down every GPIO
// - after reset release, wait 15 to 150 us before booting
// - security bit 5 set selects OTP image, else embedded flash
// - embedded flash is reached through the first tile's I/O ports
// - read 32-bit word count s, then exactly four times s bytes
// - then read check word; marker 0x0D15AB1E skips the check
// - size and check words arrive least significant byte first
// - program goes to lowest RAM address; start execution there
// - check value covers size word and program bytes, not check word
// - reflected poly 0xEDB88320, preset all ones, final value inverted
package bil_pkg;

  localparam int          BOOT_DELAY_NS  = 15000;
  localparam int          CLOCK_NS       = 40;
  // least time rounds up to whole cycles
  localparam int          BOOT_DELAY_CYC = (BOOT_DELAY_NS + CLOCK_NS - 1)
                                           / CLOCK_NS;
  localparam int          SEC_OTP_BIT    = 5;
  localparam logic [31:0] SKIP_MARKER    = 32'h0D15AB1E;
  localparam logic [31:0] CRC_POLY       = 32'hEDB88320;
  localparam logic [31:0] CRC_PRESET     = 32'hFFFFFFFF;
  localparam logic [31:0] BOOT_PC        = 32'h00000000;

  typedef enum logic [2:0] {
    ST_DELAY, ST_SIZE, ST_PROG, ST_CHECK, ST_RUN, ST_FAIL
  } bil_state_t;

  // one byte write into program RAM
  typedef struct packed {
    logic        we;
    logic [31:0] addr;
    logic [7:0]  data;
  } bil_ram_wr_t;

  // boot result seen by the processor start logic
  typedef struct packed {
    logic        run;
    logic        fail;
    logic        skipped;
    logic [31:0] pc;
  } bil_status_t;

endpackage

// ==== verilog/bil_loader.sv ====
// boot image loader: byte link, image parser, crc check and ram writes
`timescale 1ns/10ps
module bil_loader
#(
  parameter int ADDR_W = 17
)
(
  input  wire logic              clock_in,
  input  wire logic              resetn_in,
  input  wire logic [31:0]       sec_config_in,
  input  wire logic              link_clock_in,
  input  wire logic              otp_valid_in,
  input  wire logic [7:0]        otp_byte_in,
  output logic                   otp_ready_out,
  input  wire logic              tile0_flash_valid_in,
  input  wire logic [7:0]        tile0_flash_byte_in,
  output logic                   tile0_flash_ready_out,
  output logic                   src_otp_out,
  output logic                   gpio_pulldown_out,
  output bil_pkg::bil_ram_wr_t   ram_wr_out,
  output bil_pkg::bil_status_t   status_out
);

  ////////////////////////////////////////////////////////////////////////
  // crc helpers

  // one byte through the reflected crc register
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ bil_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // link domain: source select, byte capture, toggle handshake

  logic [2:0] sel_sync_reg;
  logic       req_tgl_reg;
  logic [7:0] hold_reg;
  logic [2:0] ack_sync_reg;
  logic       ack_tgl_reg;
  logic       src_otp_reg;

  wire        link_sel_otp = sel_sync_reg[2];
  wire        link_free    = (req_tgl_reg == ack_sync_reg[2]);
  wire        link_valid   = link_sel_otp ? otp_valid_in
                                          : tile0_flash_valid_in;
  wire [7:0]  link_byte    = link_sel_otp ? otp_byte_in
                                          : tile0_flash_byte_in;
  wire        link_take    = link_valid & link_free;

  // only the selected source sees ready; the other stays stalled
  assign otp_ready_out         = link_free & link_sel_otp;
  assign tile0_flash_ready_out = link_free & ~link_sel_otp;

  // select level and ack toggle come from the core clock
  always_ff @(posedge link_clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sel_sync_reg <= 3'h0;
      ack_sync_reg <= 3'h0;
    end
    else
    begin
      sel_sync_reg <= {sel_sync_reg[1:0], src_otp_reg};
      ack_sync_reg <= {ack_sync_reg[1:0], ack_tgl_reg};
    end
  end

  // hold stays still until the core acknowledges, so it crosses as data
  always_ff @(posedge link_clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      req_tgl_reg <= 1'b0;
      hold_reg    <= 8'h00;
    end
    else if (link_take)
    begin
      req_tgl_reg <= ~req_tgl_reg;
      hold_reg    <= link_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core domain: request synchroniser and byte strobe

  logic [2:0]          req_sync_reg;
  logic [1:0]          bidx_reg;
  bil_pkg::bil_state_t state_reg;
  bil_pkg::bil_state_t state_next;

  // a change counts once the second and third stages agree
  wire req_level = req_sync_reg[2];
  wire req_agree = (req_sync_reg[1] == req_sync_reg[2]);
  wire parsing   = (state_reg == bil_pkg::ST_SIZE) |
                   (state_reg == bil_pkg::ST_PROG) |
                   (state_reg == bil_pkg::ST_CHECK);
  // bytes are only taken while parsing; afterwards the link back-pressures
  wire byte_stb  = parsing & req_agree & (req_level != ack_tgl_reg);
  // the last check byte is never acknowledged: the link slot stays full,
  // so ready stays low after run or fail until the next reset
  wire last_chk  = (state_reg == bil_pkg::ST_CHECK) & (bidx_reg == 2'h3);
  wire [7:0] rx_byte = hold_reg;

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      req_sync_reg <= 3'h0;
      ack_tgl_reg  <= 1'b0;
    end
    else
    begin
      req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
      if (byte_stb & ~last_chk)
      begin
        ack_tgl_reg <= req_level;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // image parser datapath

  logic [15:0] delay_reg;
  logic [31:0] word_reg;
  logic [33:0] remain_reg;
  logic [31:0] crc_reg;
  logic [31:0] addr_reg;

  // bytes assemble least significant first
  wire [31:0] word_now  = {rx_byte, word_reg[31:8]};
  wire        word_done = byte_stb & (bidx_reg == 2'h3);
  wire [31:0] crc_now   = crc_byte(crc_reg, rx_byte);
  wire        delay_end = (delay_reg ==
                           16'(bil_pkg::BOOT_DELAY_CYC - 1));
  wire [33:0] prog_len  = {word_now, 2'b00};
  wire        is_skip   = (word_now == bil_pkg::SKIP_MARKER);
  wire        crc_ok    = (word_now == ~crc_reg);
  wire        last_prog = (remain_reg == 34'h000000001);

  // state sequencing
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      bil_pkg::ST_DELAY:
        if (delay_end)
          state_next = bil_pkg::ST_SIZE;
      bil_pkg::ST_SIZE:
        if (word_done)
          state_next = (word_now == 32'h00000000) ? bil_pkg::ST_CHECK
                                                  : bil_pkg::ST_PROG;
      bil_pkg::ST_PROG:
        if (byte_stb & last_prog)
          state_next = bil_pkg::ST_CHECK;
      bil_pkg::ST_CHECK:
        if (word_done)
          state_next = (is_skip | crc_ok) ? bil_pkg::ST_RUN
                                          : bil_pkg::ST_FAIL;
      bil_pkg::ST_RUN:
        state_next = bil_pkg::ST_RUN;
      bil_pkg::ST_FAIL:
        state_next = bil_pkg::ST_FAIL;
    endcase
  end

  // state, boot delay and source latch; source is caught after release
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_reg   <= bil_pkg::ST_DELAY;
      delay_reg   <= 16'h0000;
      src_otp_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == bil_pkg::ST_DELAY)
      begin
        delay_reg   <= delay_reg + 16'h0001;
        src_otp_reg <= sec_config_in[bil_pkg::SEC_OTP_BIT];
      end
    end
  end

  // word assembly, length count and crc over size and program only
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      bidx_reg   <= 2'h0;
      word_reg   <= 32'h00000000;
      remain_reg <= 34'h000000000;
      crc_reg    <= bil_pkg::CRC_PRESET;
    end
    else if (byte_stb)
    begin
      word_reg <= word_now;
      bidx_reg <= (state_reg == bil_pkg::ST_PROG) ? 2'h0
                                                  : bidx_reg + 2'h1;
      if (state_reg != bil_pkg::ST_CHECK)
      begin
        crc_reg <= crc_now;
      end
      if (word_done & (state_reg == bil_pkg::ST_SIZE))
      begin
        remain_reg <= prog_len;
      end
      else if (state_reg == bil_pkg::ST_PROG)
      begin
        remain_reg <= remain_reg - 34'h000000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ram writes and status

  bil_pkg::bil_ram_wr_t ram_wr_reg;
  bil_pkg::bil_status_t status_reg;
  logic                 pulldown_reg;

  wire prog_wr = byte_stb & (state_reg == bil_pkg::ST_PROG);

  // ram address starts at the lowest location and climbs by one byte
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      addr_reg   <= bil_pkg::BOOT_PC;
      ram_wr_reg <= '0;
    end
    else
    begin
      ram_wr_reg.we   <= prog_wr;
      ram_wr_reg.addr <= addr_reg;
      ram_wr_reg.data <= rx_byte;
      if (prog_wr)
      begin
        addr_reg <= addr_reg + 32'h00000001;
      end
    end
  end

  // pull-down holds from reset until the boot delay is over
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pulldown_reg <= 1'b1;
      status_reg   <= '0;
    end
    else
    begin
      if (delay_end)
      begin
        pulldown_reg <= 1'b0;
      end
      status_reg.pc <= bil_pkg::BOOT_PC;
      if (state_reg == bil_pkg::ST_CHECK & word_done)
      begin
        status_reg.run     <= is_skip | crc_ok;
        status_reg.fail    <= ~(is_skip | crc_ok);
        status_reg.skipped <= is_skip;
      end
    end
  end

  // address is truncated to the ram width; high bits read zero
  always_comb
  begin
    ram_wr_out      = ram_wr_reg;
    ram_wr_out.addr = {{(32 - ADDR_W){1'b0}}, ram_wr_reg.addr[ADDR_W-1:0]};
  end

  assign status_out        = status_reg;
  assign src_otp_out       = src_otp_reg;
  assign gpio_pulldown_out = pulldown_reg;

endmodule

// ==== sim/bil_loader_sva.sv ====
// checker: timing and status relations of the boot image loader
`timescale 1ns/10ps
module bil_loader_sva
(
  input wire logic                 clock_in,
  input wire logic                 resetn_in,
  input wire logic                 otp_ready_out,
  input wire logic                 tile0_flash_ready_out,
  input wire logic                 src_otp_out,
  input wire logic                 gpio_pulldown_out,
  input wire bil_pkg::bil_ram_wr_t ram_wr_out,
  input wire bil_pkg::bil_status_t status_out
);
  logic [11:0] cyc_reg;
  logic [31:0] wr_reg;
  ////////////////////////////////////////////////////////////////////////////
  // cycles since release, saturated so a long run never wraps
  always_ff @(posedge clock_in or negedge resetn_in)
    if (!resetn_in)
    begin
      cyc_reg <= 12'h000;
      wr_reg  <= 32'h00000000;
    end
    else
    begin
      cyc_reg <= cyc_reg + {11'h000, cyc_reg != 12'hFFF};
      wr_reg  <= wr_reg + {31'h00000000, ram_wr_out.we};
    end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  sequence s_done; status_out.run || status_out.fail; endsequence
  sequence s_shut; !otp_ready_out && !tile0_flash_ready_out; endsequence
  property p_hold; cyc_reg < 12'h177 |-> gpio_pulldown_out; endproperty
  property p_late; cyc_reg >= 12'h177 |-> !gpio_pulldown_out; endproperty
  property p_quiet; ram_wr_out.we |-> !gpio_pulldown_out; endproperty
  property p_addr; ram_wr_out.we |-> ram_wr_out.addr == wr_reg; endproperty
  property p_pc; s_done |-> status_out.pc == bil_pkg::BOOT_PC; endproperty
  property p_once;
    s_done |=> $stable(status_out) && !(status_out.run && status_out.fail);
  endproperty
  property p_skip; status_out.skipped |-> status_out.run; endproperty
  property p_shut; s_done |-> s_shut; endproperty
  property p_src;
    !gpio_pulldown_out |->
      (src_otp_out ? !tile0_flash_ready_out : !otp_ready_out);
  endproperty
  property p_nowr; s_done |-> !ram_wr_out.we; endproperty
  a_hold: assert property (p_hold)
    else $error("pull-down released before boot delay");
  a_late: assert property (p_late)
    else $error("boot not started after the boot delay");
  a_quiet: assert property (p_quiet)
    else $error("ram write during boot delay");
  a_addr: assert property (p_addr)
    else $error("ram write address out of order");
  a_pc: assert property (p_pc)
    else $error("start address not lowest ram address");
  a_once: assert property (p_once)
    else $error("status changed or both run and fail");
  a_skip: assert property (p_skip)
    else $error("skipped flagged without run");
  a_shut: assert property (p_shut)
    else $error("link still accepting after boot finished");
  a_src: assert property (p_src)
    else $error("unselected source accepting bytes");
  a_nowr: assert property (p_nowr)
    else $error("ram write after boot finished");
endmodule
bind bil_loader bil_loader_sva u_sva (.clock_in(clock_in),
  .resetn_in(resetn_in), .otp_ready_out(otp_ready_out),
  .tile0_flash_ready_out(tile0_flash_ready_out), .src_otp_out(src_otp_out),
  .gpio_pulldown_out(gpio_pulldown_out), .ram_wr_out(ram_wr_out),
  .status_out(status_out));

// ==== sim/bil_byte_src.sv ====
// partner model: byte source of a boot memory on the link clock
`timescale 1ns/10ps
module bil_byte_src
(
  input  wire logic       link_clock_in,
  input  wire logic       ready_in,
  input  wire logic       slow_in,
  output logic            valid_out,
  output logic [7:0]      byte_out
);
  logic [7:0] q[$];
  logic       hold;
  initial valid_out = 1'h0;
  initial byte_out = 8'h5A;
  ////////////////////////////////////////////////////////////////////////////
  // a byte stays up until taken; idle data toggles so stale bytes never match
  always @(posedge link_clock_in)
  begin
    hold = 1'h0;
    if (valid_out && ready_in)
    begin
      void'(q.pop_front());
      hold = slow_in;
    end
    if (q.size() != 0 && !hold)
    begin
      valid_out <= 1'h1;
      byte_out <= q[0];
    end
    else
    begin
      valid_out <= 1'h0;
      byte_out <= ~byte_out;
    end
  end
endmodule

// ==== sim/bil_loader_bench.sv ====
// testbench: boots four images from both sources and checks the results
`timescale 1ns/10ps
module bil_loader_bench;
  logic                 clock_in = 1'h0, link_clock_in = 1'h0;
  logic                 resetn_in = 1'h0, slow = 1'h0;
  logic [31:0]          sec_config_in = 32'h0;
  integer               seed = 32'h8D86;
  logic                 otp_valid_in, tile0_flash_valid_in, done_d;
  logic [7:0]           otp_byte_in, tile0_flash_byte_in;
  logic                 otp_ready_out, tile0_flash_ready_out;
  logic                 src_otp_out, gpio_pulldown_out;
  bil_pkg::bil_ram_wr_t ram_wr_out;
  bil_pkg::bil_status_t status_out;
  logic [40:0]          exp_q[$];
  int                   failures = 0, total_checks = 0;
  always #20 clock_in = ~clock_in;
  always #32 link_clock_in = ~link_clock_in;
  bil_loader u_bil_loader (.clock_in(clock_in), .resetn_in(resetn_in),
    .sec_config_in(sec_config_in), .link_clock_in(link_clock_in),
    .otp_valid_in(otp_valid_in), .otp_byte_in(otp_byte_in),
    .otp_ready_out(otp_ready_out),
    .tile0_flash_valid_in(tile0_flash_valid_in),
    .tile0_flash_byte_in(tile0_flash_byte_in),
    .tile0_flash_ready_out(tile0_flash_ready_out),
    .src_otp_out(src_otp_out), .gpio_pulldown_out(gpio_pulldown_out),
    .ram_wr_out(ram_wr_out), .status_out(status_out));
  bil_byte_src u_bil_byte_src (.link_clock_in(link_clock_in),
    .ready_in(otp_ready_out), .slow_in(slow), .valid_out(otp_valid_in),
    .byte_out(otp_byte_in));
  bil_byte_src u_bil_byte_src_f (.link_clock_in(link_clock_in),
    .ready_in(tile0_flash_ready_out), .slow_in(slow),
    .valid_out(tile0_flash_valid_in), .byte_out(tile0_flash_byte_in));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [40:0] e, input logic [40:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // reflected step, written apart from the design so errors are independent
  function automatic logic [31:0] step(logic [31:0] c, logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int k = 0; k < 8; k++)
      c = c[0] ? (c >> 1) ^ bil_pkg::CRC_POLY : c >> 1;
    return c;
  endfunction
  task put(input logic otp, input logic [7:0] b);
    if (otp)
      u_bil_byte_src.q.push_back(b);
    else
      u_bil_byte_src_f.q.push_back(b);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // mode 0 flash good, 1 otp marker, 2 flash bad with size 0, 3 otp good
  task run(input int mode);
    logic [31:0] crc, w, cw;
    logic [7:0]  b;
    logic        otp;
    otp = mode[0];
    w = mode == 2 ? 32'h0 : 32'h1 + ($random(seed) & 32'h3);
    @(posedge clock_in);
    resetn_in <= 1'h0;
    sec_config_in <= ($random(seed) & ~32'h20) | {26'h0, otp, 5'h0};
    slow <= $random(seed);
    repeat (5) @(posedge clock_in);
    resetn_in <= 1'h1;
    chk("pulldown", 41'h1, {40'h0, gpio_pulldown_out});
    repeat (400) @(posedge clock_in);
    chk("source", {40'h0, otp}, {40'h0, src_otp_out});
    chk("pulldown", 41'h0, {40'h0, gpio_pulldown_out});
    crc = bil_pkg::CRC_PRESET;
    for (int i = 0; i < 4; i++)
    begin
      crc = step(crc, w[8*i +: 8]);
      put(otp, w[8*i +: 8]);
    end
    for (int i = 0; i < 4 * w; i++)
    begin
      b = $random(seed);
      crc = step(crc, b);
      put(otp, b);
      exp_q.push_back({1'h0, i[31:0], b});
    end
    cw = mode == 1 ? bil_pkg::SKIP_MARKER : ~crc ^ {31'h0, mode == 2};
    for (int i = 0; i < 4; i++)
      put(otp, cw[8*i +: 8]);
    exp_q.push_back({1'h1, 29'h0, mode != 2, mode == 2, mode == 1, 8'h0});
    for (int t = 0; t < 5000 && exp_q.size() != 0; t++)
      @(posedge clock_in);
    chk("drained", 41'h0, {9'h0, 32'(exp_q.size())});
    $display("test mode %0d finished", mode);
  endtask
  // compare each ram write and the final status with the oldest note;
  // looked at on the falling edge, where registered outputs have settled
  always @(negedge clock_in)
  begin
    if (ram_wr_out.we === 1'h1 || (done_d === 1'h0 &&
        (status_out.run | status_out.fail) === 1'h1))
      chk("result", exp_q.size() != 0 ? exp_q.pop_front() : 41'h1FFFFFFFFFF,
          ram_wr_out.we === 1'h1 ? {1'h0, ram_wr_out.addr, ram_wr_out.data}
          : {1'h1, 29'h0, status_out.run, status_out.fail,
             status_out.skipped, 8'h0});
    done_d = status_out.run | status_out.fail;
  end
  initial
  begin
    for (int m = 0; m < 4; m++)
      run(m);
    print_verdict;
  end
  initial
  begin
    #400000;
    failures++;
    print_verdict;
  end
endmodule
